/* File: aof_pkg.sv */
// Purpose: shared constants and types of the output formatter
// Assumes: 8-bit register port, 18-bit internal sample word
// Notes: offsets are register addresses on the configuration port
package aof_pkg;

	// ----------------------------------------------------------
	// Register map
	// ----------------------------------------------------------
	localparam logic [7:0] ADDR_FMT   = 8'h62;
	localparam logic [7:0] ADDR_PA_LO = 8'h74;
	localparam logic [7:0] ADDR_PA_HI = 8'h75;
	localparam logic [7:0] ADDR_PB_LO = 8'h76;
	localparam logic [7:0] ADDR_PB_HI = 8'h77;
	localparam logic [7:0] ADDR_STAT  = 8'h78;

	// ----------------------------------------------------------
	// Format register fields and reset values
	// ----------------------------------------------------------
	localparam logic [7:0]  FMT_RST    = 8'h10;
	localparam int          FMT_STREAM = 6;
	localparam int          FMT_CODING = 5;
	localparam int          FMT_MODE   = 3;
	localparam int          FMT_TP     = 0;
	localparam logic [15:0] PAT_RST    = 16'h0000;

	// ----------------------------------------------------------
	// Modes and selections
	// ----------------------------------------------------------
	typedef enum logic [1:0] {
		OM_OFF  = 2'h0,
		OM_CMOS = 2'h1,
		OM_EVEN = 2'h2,
		OM_MSB  = 2'h3
	} aof_omode_t;

	typedef enum logic [2:0] {
		TP_ADC   = 3'h0,
		TP_CUST  = 3'h1,
		TP_RAMP  = 3'h2,
		TP_ALTC2 = 3'h3,
		TP_ALTC1 = 3'h4,
		TP_ALTL  = 3'h5,
		TP_SYNC  = 3'h6,
		TP_PRS   = 3'h7
	} aof_tpat_t;

	typedef enum logic [1:0] {
		SER_FILL = 2'b01,
		SER_SEND = 2'b10
	} aof_ser_t;

	localparam logic [1:0] RES_16 = 2'h0;
	localparam logic [1:0] RES_14 = 2'h1;
	localparam logic [1:0] RES_18 = 2'h2;

	// ----------------------------------------------------------
	// Pattern words and timing counts
	// ----------------------------------------------------------
	localparam logic [15:0] SYNC_WORD  = 16'hff00;
	localparam logic [1:0]  SYNC_TAIL  = 2'h2;
	localparam logic [15:0] ALT_L16    = 16'h55aa;
	localparam logic [15:0] ALT_L14    = 16'h55a8;
	localparam logic [15:0] ALT_C      = 16'h5555;
	localparam logic [3:0]  RAMP_DV18  = 4'h0;
	localparam logic [3:0]  RAMP_DV16  = 4'h3;
	localparam logic [3:0]  RAMP_DV14  = 4'hf;
	localparam logic [15:0] LFSR_TAPS  = 16'hb400;
	localparam logic [15:0] LFSR_SEED  = 16'h0001;
	localparam logic [2:0]  SER_LAST   = 3'h7;
	localparam logic [2:0]  CH_LAST    = 3'h7;

endpackage

/* File: aof_sync.sv */
// Purpose: three-stage level synchroniser with agreement filter
// Assumes: source levels are quasi-static
// Notes: the word changes once stages two and three agree in full
`timescale 1ns/1ps
module aof_sync #(
	parameter int             W    = 1,
	parameter logic [W-1:0]   INIT = '0
) (
	// Destination clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Source level and filtered copy
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;
	logic [W-1:0] q_reg;
	logic [W-1:0] q_next;
	logic [W-1:0] agree;

	// Shift chain; first stage feeds only the second
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_reg <= INIT;
			s2_reg <= INIT;
			s3_reg <= INIT;
			q_reg  <= INIT;
		end else begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			q_reg  <= q_next;
		end
	end

	// Take the word only when all bits of the last two stages agree, so no torn word passes
	assign agree  = s2_reg ~^ s3_reg;
	assign q_next = (&agree) ? s2_reg : q_reg;
	assign q      = q_reg;
endmodule

/* File: aof_formatter.sv */
// Purpose: output formatting and test patterns of the converter
// Assumes: sample data and valid arrive on LINK_CLK
// Notes: DDR cells outside take LVDS_RISE and LVDS_FALL
`timescale 1ns/1ps

// Operation
// - Stream bit 6 picks serialized (1) or interleaved (0, reset) octal streaming.
// - Stream selection acts only in octal-channel mode.
// - Serialized only for octal 16-bit; pair 7 first channel, pair 0 last.
// - Serialized streaming needs octal post-processing enable set.
// - Interleaved streaming outputs channel words in sampling order.
// - Coding bit: 1 offset binary, 0 two's complement (reset).
// - Interface: 11 MSb-byte DDR, 10 even-bit DDR (reset), 01 CMOS, 00 off.
// - MSb-byte DDR only at 16 bits: bits 15:8 rise, 7:0 fall.
// - Even-bit DDR: even bits on rise, odd bits on fall, paired.
// - Pattern 111 outputs a pseudo-random LFSR sequence.
// - Pattern 110 outputs sync word, ones then zeros, 18-bit ends 10.
// - Pattern 101 outputs 01010101 10101010, truncated at 14 bits.
// - Pattern 100 alternates all ones and all zeros on CMOS.
// - Pattern 011 alternates 0x5555 and 0xaaaa on CMOS.
// - Pattern 010 ramps: every 1, 4, 16 cycles for 18, 16, 14 bits.
// - Pattern 001 alternates custom patterns A and B.
// - Pattern 000 passes converted data; reset selection.
// - Custom mode: A bits 15:14 drive overrange, B bits 15:14 word clock.
// - Custom mode: bits 1:0 of A or B drive the extra low bits.
module aof_formatter (
	// Core clock, reset and freeze
	input  wire logic        REF_CLK,
	input  wire logic        RST,
	input  wire logic        CE,
	// Configuration register port
	input  wire logic        REG_WE,
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [7:0]  REG_WDATA,
	output logic      [7:0]  REG_RDATA,
	// Channel mode straps
	input  wire logic        OCTAL_MODE,
	input  wire logic        OCTAL_POSTPROC_ENABLE,
	input  wire logic [1:0]  RES_MODE,
	// Sample input on the link clock
	input  wire logic        LINK_CLK,
	input  wire logic        ADC_VALID,
	input  wire logic [17:0] ADC_DATA,
	input  wire logic        ADC_OVR,
	// Output pins
	output logic             OUT_EN,
	output logic      [15:0] CMOS_Q,
	output logic      [7:0]  LVDS_RISE,
	output logic      [7:0]  LVDS_FALL,
	output logic      [1:0]  OVERRANGE_OUT,
	output logic      [1:0]  WORD_CLOCK_OUT,
	output logic             EXTRA_LOW_BIT_ONE,
	output logic             EXTRA_LOW_BIT_TWO
);

	// ----------------------------------------------------------
	// Functions
	// ----------------------------------------------------------

	// Converted data coding; MSb flip gives offset binary
	function automatic logic [17:0] code_word(input logic [17:0] d, input logic ob);
		code_word = {d[17] ^ ob, d[16:0]};
	endfunction

	// Split a word into rising and falling halves
	function automatic logic [15:0] ddr_split(input logic msb_first, input logic [15:0] q);
		logic [7:0] ev;
		logic [7:0] od;
		for (int i = 0; i < 8; i++) begin
			ev[i] = q[2*i];
			od[i] = q[2*i+1];
		end
		ddr_split = msb_first ? q : {ev, od};
	endfunction

	// Galois step of the pseudo-random generator
	function automatic logic [15:0] prs_step(input logic [15:0] v);
		prs_step = v[0] ? ((v >> 1) ^ aof_pkg::LFSR_TAPS) : (v >> 1);
	endfunction

	// ----------------------------------------------------------
	// Register port on REF_CLK
	// ----------------------------------------------------------
	logic [6:0]  fmt_reg;
	logic [15:0] pat_a_reg;
	logic [15:0] pat_b_reg;
	logic [7:0]  rdata_reg;
	logic [1:0]  stat_ref;
	logic        wr_en;
	logic [7:0]  rdata_next;

	assign wr_en = REG_WE && CE;

	// Register writes, bit 7 of the format register not kept
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			fmt_reg   <= aof_pkg::FMT_RST[6:0];
			pat_a_reg <= aof_pkg::PAT_RST;
			pat_b_reg <= aof_pkg::PAT_RST;
		end else if (wr_en) begin
			if (REG_ADDR == aof_pkg::ADDR_FMT) begin
				fmt_reg <= REG_WDATA[6:0];
			end else if (REG_ADDR == aof_pkg::ADDR_PA_LO) begin
				pat_a_reg[7:0] <= REG_WDATA;
			end else if (REG_ADDR == aof_pkg::ADDR_PA_HI) begin
				pat_a_reg[15:8] <= REG_WDATA;
			end else if (REG_ADDR == aof_pkg::ADDR_PB_LO) begin
				pat_b_reg[7:0] <= REG_WDATA;
			end else if (REG_ADDR == aof_pkg::ADDR_PB_HI) begin
				pat_b_reg[15:8] <= REG_WDATA;
			end
		end
	end

	// Read selection; unmapped addresses read zero
	assign rdata_next = (REG_ADDR == aof_pkg::ADDR_FMT)   ? {1'b0, fmt_reg} :
	                    (REG_ADDR == aof_pkg::ADDR_PA_LO) ? pat_a_reg[7:0] :
	                    (REG_ADDR == aof_pkg::ADDR_PA_HI) ? pat_a_reg[15:8] :
	                    (REG_ADDR == aof_pkg::ADDR_PB_LO) ? pat_b_reg[7:0] :
	                    (REG_ADDR == aof_pkg::ADDR_PB_HI) ? pat_b_reg[15:8] :
	                    (REG_ADDR == aof_pkg::ADDR_STAT)  ? {6'h00, stat_ref} : 8'h00;

	// Read data register
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			rdata_reg <= 8'h00;
		end else if (CE) begin
			rdata_reg <= rdata_next;
		end
	end

	assign REG_RDATA = rdata_reg;

	// ----------------------------------------------------------
	// Crossings into and out of the link domain
	// ----------------------------------------------------------
	localparam int CW = 44;
	localparam logic [CW-1:0] CFG_INIT = {3'h0, aof_pkg::RES_16, aof_pkg::FMT_RST[6:0],
	                                      aof_pkg::PAT_RST, aof_pkg::PAT_RST};
	logic [CW-1:0] cfg_l;
	logic [1:0]    stat_reg;

	// Configuration, straps and freeze into LINK_CLK
	aof_sync #(.W(CW), .INIT(CFG_INIT)) u_cfg_sync (
		.clk (LINK_CLK),
		.rst (RST),
		.d   ({CE, OCTAL_MODE, OCTAL_POSTPROC_ENABLE, RES_MODE, fmt_reg, pat_b_reg, pat_a_reg}),
		.q   (cfg_l)
	);

	// Link status back into REF_CLK
	aof_sync #(.W(2), .INIT(2'h0)) u_stat_sync (
		.clk (REF_CLK),
		.rst (RST),
		.d   (stat_reg),
		.q   (stat_ref)
	);

	// ----------------------------------------------------------
	// Link-side configuration decode
	// ----------------------------------------------------------
	logic                l_ce;
	logic [1:0]          l_res;
	logic [6:0]          l_fmt;
	logic [15:0]         l_pa;
	logic [15:0]         l_pb;
	logic                octal_stream_type_select;
	aof_pkg::aof_omode_t omode;
	aof_pkg::aof_tpat_t  tpat;
	logic                ser_allowed;
	logic                msb_first;
	logic                stb;

	assign l_ce  = cfg_l[43];
	assign l_res = cfg_l[40:39];
	assign l_fmt = cfg_l[38:32];
	assign l_pb  = cfg_l[31:16];
	assign l_pa  = cfg_l[15:0];
	assign octal_stream_type_select = l_fmt[aof_pkg::FMT_STREAM];
	assign omode = aof_pkg::aof_omode_t'(l_fmt[aof_pkg::FMT_MODE +: 2]);
	assign tpat  = aof_pkg::aof_tpat_t'(l_fmt[aof_pkg::FMT_TP +: 3]);
	// Serial streaming gated by octal mode, post-processing and 16 bits
	assign ser_allowed = octal_stream_type_select && cfg_l[42] && cfg_l[41]
	                     && l_res == aof_pkg::RES_16 && omode != aof_pkg::OM_CMOS
	                     && omode != aof_pkg::OM_OFF;
	assign msb_first = omode == aof_pkg::OM_MSB && l_res == aof_pkg::RES_16;
	// Words advance on each sample, or each cycle under a pattern
	assign stb = l_ce && (tpat == aof_pkg::TP_ADC ? ADC_VALID : 1'b1);

	// ----------------------------------------------------------
	// Pattern generators
	// ----------------------------------------------------------
	logic [15:0] pseudo_random_sequence;
	logic [17:0] ramp_reg;
	logic [3:0]  div_reg;
	logic [3:0]  div_last;
	logic        ab_reg;

	assign div_last = (l_res == aof_pkg::RES_18) ? aof_pkg::RAMP_DV18 :
	                  (l_res == aof_pkg::RES_14) ? aof_pkg::RAMP_DV14 : aof_pkg::RAMP_DV16;

	// Ramp with per-resolution step interval
	always_ff @(posedge LINK_CLK or posedge RST) begin
		if (RST) begin
			ramp_reg <= 18'h00000;
			div_reg  <= 4'h0;
		end else if (l_ce) begin
			if (tpat != aof_pkg::TP_RAMP) begin
				ramp_reg <= 18'h00000;
				div_reg  <= 4'h0;
			end else if (div_reg >= div_last) begin
				ramp_reg <= ramp_reg + 18'h00001;
				div_reg  <= 4'h0;
			end else begin
				div_reg <= div_reg + 4'h1;
			end
		end
	end

	// Pseudo-random sequence and word phase
	always_ff @(posedge LINK_CLK or posedge RST) begin
		if (RST) begin
			pseudo_random_sequence <= aof_pkg::LFSR_SEED;
			ab_reg                 <= 1'b0;
		end else if (stb) begin
			if (tpat == aof_pkg::TP_PRS) begin
				pseudo_random_sequence <= prs_step(pseudo_random_sequence);
			end
			ab_reg <= ~ab_reg;
		end
	end

	// ----------------------------------------------------------
	// Word selection
	// ----------------------------------------------------------
	logic [17:0] adc_word;
	logic [17:0] ramp_word;
	logic [15:0] cust_q;
	logic [17:0] src_word;

	assign adc_word  = code_word(ADC_DATA, l_fmt[aof_pkg::FMT_CODING]);
	assign ramp_word = (l_res == aof_pkg::RES_18) ? ramp_reg :
	                   (l_res == aof_pkg::RES_14) ? {ramp_reg[13:0], 4'h0} : {ramp_reg[15:0], 2'h0};
	assign cust_q    = ab_reg ? l_pb : l_pa;

	// Source word per pattern selection
	always_comb begin
		case (tpat)
			aof_pkg::TP_ADC:   src_word = adc_word;
			aof_pkg::TP_PRS:   src_word = {pseudo_random_sequence, 2'h0};
			aof_pkg::TP_SYNC:  src_word = {aof_pkg::SYNC_WORD,
			                              l_res == aof_pkg::RES_18 ? aof_pkg::SYNC_TAIL : 2'h0};
			aof_pkg::TP_ALTL:  src_word = {l_res == aof_pkg::RES_14 ? aof_pkg::ALT_L14 :
			                              aof_pkg::ALT_L16, 2'h0};
			aof_pkg::TP_ALTC1: src_word = {{16{ab_reg}}, 2'h0};
			aof_pkg::TP_ALTC2: src_word = {ab_reg ? ~aof_pkg::ALT_C : aof_pkg::ALT_C, 2'h0};
			aof_pkg::TP_RAMP:  src_word = ramp_word;
			aof_pkg::TP_CUST:  src_word = {cust_q, cust_q[1:0]};
			default:           src_word = adc_word;
		endcase
	end

	// ----------------------------------------------------------
	// Serialized octal stream
	// ----------------------------------------------------------
	aof_pkg::aof_ser_t ser_state;
	logic [15:0]       frame_mem [8];
	logic [15:0]       shf_reg [8];
	logic [2:0]        ch_reg;
	logic [2:0]        cnt_reg;
	logic              rdy_reg;
	logic              load;
	logic              frame_done;
	logic [15:0]       ser_bits;

	assign frame_done = stb && ch_reg == aof_pkg::CH_LAST;
	assign load = rdy_reg && (ser_state == aof_pkg::SER_FILL ||
	                          cnt_reg == aof_pkg::SER_LAST);

	// Frame capture in arrival order, channel 0 first
	always_ff @(posedge LINK_CLK or posedge RST) begin
		if (RST) begin
			ch_reg  <= 3'h0;
			rdy_reg <= 1'b0;
		end else if (l_ce) begin
			ch_reg  <= !ser_allowed ? 3'h0 : stb ? ch_reg + 3'h1 : ch_reg;
			rdy_reg <= ser_allowed && (frame_done || (rdy_reg && !load)); // set wins
		end
	end

	always_ff @(posedge LINK_CLK) begin
		if (stb && ser_allowed) begin
			frame_mem[ch_reg] <= src_word[17:2];
		end
	end

	// Send state machine, two bits per pair each cycle
	always_ff @(posedge LINK_CLK or posedge RST) begin
		if (RST) begin
			ser_state <= aof_pkg::SER_FILL;
			cnt_reg   <= 3'h0;
		end else if (l_ce) begin
			if (!ser_allowed) begin
				ser_state <= aof_pkg::SER_FILL;
				cnt_reg   <= 3'h0;
			end else begin
				case (ser_state)
					aof_pkg::SER_FILL: begin
						ser_state <= load ? aof_pkg::SER_SEND : aof_pkg::SER_FILL;
						cnt_reg   <= 3'h0;
					end
					aof_pkg::SER_SEND: begin
						cnt_reg <= cnt_reg + 3'h1;
						if (cnt_reg == aof_pkg::SER_LAST && !rdy_reg) begin
							ser_state <= aof_pkg::SER_FILL;
						end
					end
					default: ser_state <= aof_pkg::SER_FILL;
				endcase
			end
		end
	end

	always_ff @(posedge LINK_CLK) begin
		for (int i = 0; i < 8; i++) begin
			if (l_ce && load) begin
				shf_reg[i] <= frame_mem[i];
			end else if (l_ce) begin
				shf_reg[i] <= {shf_reg[i][13:0], 2'h0};
			end
		end
	end

	// Pair 7 carries the first channel, pair 0 the last
	always_comb begin
		ser_bits = 16'h0000;
		if (ser_state == aof_pkg::SER_SEND) begin
			for (int k = 0; k < 8; k++) begin
				ser_bits[8+k] = shf_reg[7-k][15];
				ser_bits[k]   = shf_reg[7-k][14];
			end
		end
	end

	// ----------------------------------------------------------
	// Output registers
	// ----------------------------------------------------------
	logic [15:0] cmos_reg;
	logic [15:0] lvds_reg;
	logic [1:0]  ovr_reg;
	logic [1:0]  wck_reg;
	logic [1:0]  dm_reg;
	logic        oe_reg;
	logic        is_off;
	logic        is_lvds;
	logic [15:0] lvds_next;
	logic [1:0]  ovr_next;
	logic [1:0]  wck_next;

	assign is_off    = omode == aof_pkg::OM_OFF;
	assign is_lvds   = omode == aof_pkg::OM_EVEN || omode == aof_pkg::OM_MSB;
	assign lvds_next = !is_lvds ? 16'h0000 : ser_allowed ? ser_bits :
	                   ddr_split(msb_first, src_word[17:2]);
	assign ovr_next  = is_off ? 2'h0 : tpat == aof_pkg::TP_CUST ? l_pa[15:14] :
	                   tpat == aof_pkg::TP_ADC ? {2{ADC_OVR}} : 2'h0;
	assign wck_next  = is_off ? 2'h0 : tpat == aof_pkg::TP_CUST ? l_pb[15:14] :
	                   ser_allowed ? {2{~cnt_reg[2] && ser_state == aof_pkg::SER_SEND}} : 2'h2;

	// Word outputs follow the word strobe
	always_ff @(posedge LINK_CLK or posedge RST) begin
		if (RST) begin
			cmos_reg <= 16'h0000;
			dm_reg   <= 2'h0;
			ovr_reg  <= 2'h0;
		end else if (stb || (l_ce && is_off)) begin
			cmos_reg <= omode == aof_pkg::OM_CMOS ? src_word[17:2] : 16'h0000;
			dm_reg   <= is_off ? 2'h0 : src_word[1:0];
			ovr_reg  <= ovr_next;
		end
	end

	// Lane outputs step every cycle while serializing
	always_ff @(posedge LINK_CLK or posedge RST) begin
		if (RST) begin
			lvds_reg <= 16'h0000;
			wck_reg  <= 2'h0;
			oe_reg   <= 1'b0;
			stat_reg <= 2'h0;
		end else if (l_ce) begin
			if (stb || ser_allowed || is_off) begin
				lvds_reg <= lvds_next;
				wck_reg  <= wck_next;
			end
			oe_reg   <= !is_off;
			stat_reg <= {tpat != aof_pkg::TP_ADC, ser_state == aof_pkg::SER_SEND};
		end
	end

	assign OUT_EN            = oe_reg;
	assign CMOS_Q            = cmos_reg;
	assign LVDS_RISE         = lvds_reg[15:8];
	assign LVDS_FALL         = lvds_reg[7:0];
	assign OVERRANGE_OUT     = ovr_reg;
	assign WORD_CLOCK_OUT    = wck_reg;
	assign EXTRA_LOW_BIT_ONE = dm_reg[1];
	assign EXTRA_LOW_BIT_TWO = dm_reg[0];

	// ----------------------------------------------------------
	// Assertions on the link domain
	// ----------------------------------------------------------
	default clocking dck @(posedge LINK_CLK); endclocking
	default disable iff (RST);

	sequence s_cmos_pat(logic [2:0] p);
		l_ce && omode == aof_pkg::OM_CMOS && tpat == p;
	endsequence

	off_quiet_a: assert property (l_ce && is_off |=> !OUT_EN && LVDS_RISE == 8'h00)
		else $error("outputs not quiet while disabled");
	sync_word_a: assert property (l_ce && omode == aof_pkg::OM_CMOS && tpat == aof_pkg::TP_SYNC
		&& l_res == aof_pkg::RES_18 |=> CMOS_Q == 16'hff00 && EXTRA_LOW_BIT_ONE && !EXTRA_LOW_BIT_TWO)
		else $error("sync word wrong");
	alt_ones_a: assert property (s_cmos_pat(3'h4) ##1 s_cmos_pat(3'h4)
		|=> (CMOS_Q == 16'hffff || CMOS_Q == 16'h0000) && CMOS_Q != $past(CMOS_Q))
		else $error("ones/zeros alternation wrong");
	alt_fives_a: assert property (s_cmos_pat(3'h3) ##1 s_cmos_pat(3'h3)
		|=> CMOS_Q == ~$past(CMOS_Q) && (CMOS_Q == 16'h5555 || CMOS_Q == 16'haaaa))
		else $error("0x5555 alternation wrong");
	ramp_step_a: assert property (l_ce && tpat == aof_pkg::TP_RAMP && div_reg != div_last
		&& div_reg < div_last |=> ramp_reg == $past(ramp_reg))
		else $error("ramp stepped early");
	ramp_18_a: assert property ((l_ce && tpat == aof_pkg::TP_RAMP && l_res == aof_pkg::RES_18)[*2]
		|-> ramp_reg == $past(ramp_reg) + 18'h00001)
		else $error("18-bit ramp not stepping each cycle");
	msb_byte_a: assert property (stb && msb_first && !ser_allowed
		|=> LVDS_RISE == $past(src_word[17:10]) && LVDS_FALL == $past(src_word[9:2]))
		else $error("MSb-byte order wrong");
	even_bit_a: assert property (stb && omode == aof_pkg::OM_EVEN && !ser_allowed
		|=> LVDS_RISE[0] == $past(src_word[2]) && LVDS_FALL[7] == $past(src_word[17]))
		else $error("even-bit order wrong");
	ser_gate_a: assert property (l_ce && !ser_allowed |=> ser_state == aof_pkg::SER_FILL)
		else $error("serializer ran while not allowed");
	cust_pins_a: assert property (stb && tpat == aof_pkg::TP_CUST && !is_off
		|=> OVERRANGE_OUT == $past(l_pa[15:14])
		&& {EXTRA_LOW_BIT_ONE, EXTRA_LOW_BIT_TWO} == $past(cust_q[1:0]))
		else $error("custom pattern side pins wrong");
	coding_a: assert property (stb && tpat == aof_pkg::TP_ADC && omode == aof_pkg::OM_CMOS
		|=> CMOS_Q[15] == ($past(ADC_DATA[17]) ^ $past(l_fmt[5])))
		else $error("sample coding wrong");
	prs_live_a: assert property (stb && tpat == aof_pkg::TP_PRS
		|=> pseudo_random_sequence != 16'h0000 && $changed(pseudo_random_sequence))
		else $error("pseudo-random generator stuck");
endmodule

/* File: aof_rx.sv */
// Purpose: capture model of the formatter output pins
// Assumes: pins are sampled on the link clock
// Notes: rebuilds Q15..Q0 from the two DDR halves
`timescale 1ns/1ps
module aof_rx (
	// Link clock and ordering
	input  wire logic        clk,
	input  wire logic        msb_first,
	// DDR halves
	input  wire logic [7:0]  rise,
	input  wire logic [7:0]  fall,
	// Rebuilt word
	output logic      [15:0] word
);
	// Rebuild one word per link edge
	always_ff @(posedge clk) begin
		if (msb_first) begin
			word <= {rise, fall};
		end else begin
			for (int i = 0; i < 8; i++) begin
				word[2*i]   <= rise[i];
				word[2*i+1] <= fall[i];
			end
		end
	end
endmodule

/* File: tb.sv */
// Purpose: self-checking bench of the output formatter
// Assumes: straps change only between tests
// Notes: alternating patterns are checked phase-free
`timescale 1ns/1ps
module tb;
	logic        ref_clk = 0, link_clk = 0, rst = 1, ce = 1, we = 0;
	logic        octal = 0, ppen = 0, valid = 0, overrange_out = 0, msb = 0;
	logic [1:0]  res_mode = 0, ovr_o, wck_o;
	logic [7:0]  addr = 0, wdata = 0, rdata, l_rise, l_fall;
	logic [17:0] adc = 0;
	logic [15:0] cmos_q, rx_word;
	logic        out_en, dm1, dm2;
	integer      seed = 32'h7c3fcf15, miscompares = 0, tests_run = 0, cyc = 0;

	always #20 ref_clk = ~ref_clk;
	always #3 link_clk = ~link_clk;

	aof_formatter i_aof_formatter (.REF_CLK(ref_clk), .RST(rst), .CE(ce), .REG_WE(we), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_RDATA(rdata), .OCTAL_MODE(octal), .OCTAL_POSTPROC_ENABLE(ppen),
		.RES_MODE(res_mode), .LINK_CLK(link_clk), .ADC_VALID(valid), .ADC_DATA(adc), .ADC_OVR(overrange_out),
		.OUT_EN(out_en), .CMOS_Q(cmos_q), .LVDS_RISE(l_rise), .LVDS_FALL(l_fall), .OVERRANGE_OUT(ovr_o),
		.WORD_CLOCK_OUT(wck_o), .EXTRA_LOW_BIT_ONE(dm1), .EXTRA_LOW_BIT_TWO(dm2));
	aof_rx i_aof_rx (.clk(link_clk), .msb_first(msb), .rise(l_rise), .fall(l_fall), .word(rx_word));

	// Hang guard
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			end_sim();
		end
	end

	task automatic end_sim;
		$display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, exp, input string m);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge ref_clk); #1; we = 1; addr = a; wdata = d;
		@(posedge ref_clk); #1; we = 0;
		repeat (2) @(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk); #1; addr = a;
		repeat (2) @(posedge ref_clk);
		#1; d = rdata;
	endtask
	task automatic lk(input int n);
		repeat (n) @(posedge link_clk);
		#1;
	endtask
	task automatic smp(input logic [17:0] d);
		lk(1); valid = 1; adc = d; overrange_out = d[0];
		lk(1); valid = 0; lk(3);
	endtask
	task automatic pair(output logic [15:0] w0, w1);
		lk(1); w0 = cmos_q;
		lk(1); w1 = cmos_q;
	endtask
	// Interface ordering under a strap and resolution setting
	task automatic lv(input logic [7:0] f, input logic [1:0] r, input logic o, p, m);
		logic [17:0] d;
		logic [15:0] k;
		res_mode = r; octal = o; ppen = p; msb = m;
		wr(aof_pkg::ADDR_FMT, f);
		d = $random(seed);
		k = (r == 2'h1) ? 16'hfffc : 16'hffff;
		smp(d); lk(1);
		chk(rx_word & k, d[17:2] & k, "lvds order");
		chk({15'h0, out_en}, 16'h1, "out enable");
	endtask
	function automatic logic [15:0] nx(input logic [15:0] s);
		return (s >> 1) ^ (s[0] ? aof_pkg::LFSR_TAPS : 16'h0);
	endfunction

	// ----------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------
	initial begin
		logic [7:0]  r;
		logic [15:0] w0, w1, pa, pb;
		logic [17:0] d;
		logic [15:0] sw [8];
		logic [7:0]  er, ef;
		repeat (6) @(posedge ref_clk);
		#1; rst = 0;
		rd(aof_pkg::ADDR_FMT, r); chk({8'h0, r}, {8'h0, aof_pkg::FMT_RST}, "fmt reset");
		rd(8'h40, r); chk({8'h0, r}, 16'h0, "unmapped read");
		ce = 0; wr(aof_pkg::ADDR_PA_LO, 8'h5a); ce = 1;
		rd(aof_pkg::ADDR_PA_LO, r); chk({8'h0, r}, 16'h0, "write frozen");
		lk(8);
		for (int c = 0; c < 2; c++) begin
			wr(aof_pkg::ADDR_FMT, {2'b00, c[0], 5'b01000});
			repeat (4) begin
				d = $random(seed);
				smp(d);
				chk(cmos_q, d[17:2] ^ {c[0], 15'h0}, "cmos data");
				chk({14'h0, dm1, dm2}, {14'h0, d[1:0]}, "low bits");
				chk({14'h0, ovr_o}, {14'h0, {2{d[0]}}}, "overrange");
			end
		end
		$display("test cmos data done");
		lv(8'h10, 2'h0, 1'b0, 1'b0, 1'b0);
		lv(8'h18, 2'h0, 1'b0, 1'b0, 1'b1);
		lv(8'h18, 2'h1, 1'b0, 1'b0, 1'b0);
		lv(8'h50, 2'h0, 1'b0, 1'b1, 1'b0);
		lv(8'h50, 2'h0, 1'b1, 1'b0, 1'b0);
		ppen = 1; lk(8);
		for (int n = 0; n < 8; n++) begin
			d = $random(seed); sw[n] = d[17:2];
			lk(1); valid = 1; adc = d;
			lk(1); valid = 0;
		end
		lk(2);
		for (int c = 0; c < 8; c++) begin
			for (int n = 0; n < 8; n++) begin
				er[7-n] = sw[n][15-2*c];
				ef[7-n] = sw[n][14-2*c];
			end
			chk({l_rise, l_fall}, {er, ef}, "serial lanes");
			chk({14'h0, wck_o}, {14'h0, c < 4 ? 2'h3 : 2'h0}, "serial word clock");
			lk(1);
		end
		octal = 0; ppen = 0;
		$display("test serial done");
		msb = 0;
		wr(aof_pkg::ADDR_FMT, 8'h00); lk(2);
		chk({15'h0, out_en}, 16'h0, "outputs off");
		chk({l_rise, l_fall}, 16'h0, "off pins");
		$display("test interface done");
		wr(aof_pkg::ADDR_FMT, 8'h16); lk(2); chk(rx_word, aof_pkg::SYNC_WORD, "sync word");
		wr(aof_pkg::ADDR_FMT, 8'h15); lk(2); chk(rx_word, aof_pkg::ALT_L16, "lvds alt");
		wr(aof_pkg::ADDR_FMT, 8'h0c); pair(w0, w1);
		chk(w1, ~w0, "cmos ones zeros");
		chk({15'h0, w0 == 16'hffff || w0 == 16'h0}, 16'h1, "ones zeros word");
		wr(aof_pkg::ADDR_FMT, 8'h0b); pair(w0, w1);
		chk(w1, ~w0, "cmos checker");
		chk({15'h0, w0 == 16'h5555 || w0 == 16'haaaa}, 16'h1, "checker word");
		wr(aof_pkg::ADDR_FMT, 8'h0a); lk(1); w0 = cmos_q; lk(16);
		chk(cmos_q - w0, 16'h4, "ramp step");
		res_mode = 2'h2; wr(aof_pkg::ADDR_FMT, 8'h0e); lk(2);
		chk(cmos_q, aof_pkg::SYNC_WORD, "cmos sync 18");
		chk({14'h0, dm1, dm2}, {14'h0, aof_pkg::SYNC_TAIL}, "sync tail 18");
		wr(aof_pkg::ADDR_FMT, 8'h0a); lk(2); d = {cmos_q, dm1, dm2}; lk(1);
		chk(16'({cmos_q, dm1, dm2} - d), 16'h1, "ramp 18");
		wr(aof_pkg::ADDR_FMT, 8'h0f); pair(w0, w1);
		chk(w1, nx(w0), "prs step");
		pa = $random(seed);
		pb = $random(seed);
		wr(aof_pkg::ADDR_PA_LO, pa[7:0]); wr(aof_pkg::ADDR_PA_HI, pa[15:8]);
		wr(aof_pkg::ADDR_PB_LO, pb[7:0]); wr(aof_pkg::ADDR_PB_HI, pb[15:8]);
		wr(aof_pkg::ADDR_FMT, 8'h09); pair(w0, w1);
		chk({15'h0, (w0 == pa && w1 == pb) || (w0 == pb && w1 == pa)}, 16'h1, "custom swap");
		chk({12'h0, ovr_o, wck_o}, {12'h0, pa[15:14], pb[15:14]}, "custom side pins");
		chk({14'h0, dm1, dm2}, {14'h0, w1[1:0]}, "custom low bits");
		rd(aof_pkg::ADDR_STAT, r); chk({8'h0, r}, 16'h2, "status pattern");
		$display("test patterns done");
		end_sim();
	end
endmodule
